// *** design/atc_regs.vh ***
`ifndef ATC_REGS_VH
`define ATC_REGS_VH
// Register offsets (byte addresses)
`define ATC_REG_CTRL      6'h00
`define ATC_REG_GAIN1     6'h04
`define ATC_REG_GAIN2     6'h08
`define ATC_REG_OFFSET1   6'h0C
`define ATC_REG_HYST      6'h10
`define ATC_REG_SETPOINT1 6'h14
`define ATC_REG_SETPOINT2 6'h18
`define ATC_REG_STATUS    6'h1C
`define ATC_REG_VALUE1    6'h20
`define ATC_REG_VALUE2    6'h24
`define ATC_REG_DISPLAY   6'h28
// Control fields
`define ATC_CTRL_MODE_LSB 0
`define ATC_CTRL_MODE_MSB 2
`define ATC_CTRL_SRC1_LSB 4
`define ATC_CTRL_SRC1_MSB 6
`define ATC_CTRL_SRC2_LSB 8
`define ATC_CTRL_SRC2_MSB 10
`define ATC_CTRL_GAIN1_EN 12
`define ATC_CTRL_GAIN2_EN 13
`define ATC_CTRL_RESET    32'h0000_0000
// Modes
`define ATC_MODE_LESS          3'h0
`define ATC_MODE_LESS_EQUAL    3'h1
`define ATC_MODE_EQUAL         3'h2
`define ATC_MODE_GREATER_EQUAL 3'h3
`define ATC_MODE_GREATER       3'h4
// Operand sources
`define ATC_SRC_ANALOG_A 3'h0
`define ATC_SRC_ANALOG_B 3'h1
`define ATC_SRC_SETPOINT 3'h2
`define ATC_SRC_COUNTER  3'h3
`define ATC_SRC_TIMER    3'h4
// Value limits
`define ATC_PARAM_MAX    14'h270F
`define ATC_DISP_LIMIT   32'h0000_270F
`define ATC_DISP_WRAP    32'h0000_2710
`define ATC_ANALOG_BITS  10
`endif

// *** design/atc_comparator_unit.v ***
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module atc_comparator_unit
(
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        reset_n_in,
  // Wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [5:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // Operand sources
  input  wire [9:0]  analog_in_a_in,
  input  wire [9:0]  analog_in_b_in,
  input  wire [15:0] counter_value_in,
  input  wire [15:0] timer_value_in,
  // Scan control
  input  wire        scan_start_in,
  input  wire        enable_in,
  // Contact
  output reg         contact_out,
  output reg         eval_done_out
);

  reg  [31:0] ctrl;
  reg  [13:0] gain_first;
  reg  [13:0] gain_second;
  reg  [13:0] offset_first;
  reg  [13:0] switch_hysteresis;
  reg  [13:0] setpoint_first;
  reg  [13:0] setpoint_second;
  reg  signed [31:0] operand_first;
  reg  signed [31:0] operand_second;
  reg  [31:0] display_value;
  reg         eval_pending;
  reg  [31:0] next_rd;
  reg  signed [31:0] raw1;
  reg  signed [31:0] raw2;
  reg  signed [31:0] eff1;
  reg  signed [31:0] eff2;
  reg  signed [31:0] band_hi;
  reg  signed [31:0] band_lo;
  reg         next_contact;
  wire [2:0]  mode;
  wire        wb_req;
  wire        wb_write;
  wire        src1_counter;
  wire        cmp_below;
  wire        cmp_equal;
  wire        cmp_above;
  wire        cmp_not_above;
  wire        cmp_not_below;
  wire        over_band;
  wire        under_band;

  ////////////////////////////////////////////////////////////////////////////////
  // Control decode
  assign mode         = ctrl[`ATC_CTRL_MODE_MSB:`ATC_CTRL_MODE_LSB];
  assign wb_req       = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wb_write     = wb_req & wb_we_in & (wb_sel_in == 4'hF);
  assign src1_counter = (ctrl[`ATC_CTRL_SRC1_MSB:`ATC_CTRL_SRC1_LSB] == `ATC_SRC_COUNTER);

  ////////////////////////////////////////////////////////////////////////////////
  // Operand selection
  function [31:0] atc_pick;
    input [2:0]  src;
    input [9:0]  an_a;
    input [9:0]  an_b;
    input [13:0] setp;
    input [15:0] cnt;
    input [15:0] tmr;
    begin
      case (src)
        `ATC_SRC_ANALOG_A: atc_pick = {22'h000000, an_a};
        `ATC_SRC_ANALOG_B: atc_pick = {22'h000000, an_b};
        `ATC_SRC_SETPOINT: atc_pick = {18'h00000, setp};
        `ATC_SRC_COUNTER:  atc_pick = {16'h0000, cnt};
        `ATC_SRC_TIMER:    atc_pick = {16'h0000, tmr};
        default:           atc_pick = 32'h0000_0000;
      endcase
    end
  endfunction

  always @*
  begin
    raw1 = atc_pick(ctrl[`ATC_CTRL_SRC1_MSB:`ATC_CTRL_SRC1_LSB], analog_in_a_in,
                    analog_in_b_in, setpoint_first, counter_value_in, timer_value_in);
  end

  always @*
  begin
    raw2 = atc_pick(ctrl[`ATC_CTRL_SRC2_MSB:`ATC_CTRL_SRC2_LSB], analog_in_a_in,
                    analog_in_b_in, setpoint_second, counter_value_in, timer_value_in);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scaling of operand one
  always @*
  begin
    if (ctrl[`ATC_CTRL_GAIN1_EN])
      eff1 = operand_first * $signed({18'h00000, gain_first});
    else
      eff1 = operand_first;
    eff1 = eff1 + $signed({18'h00000, offset_first});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scaling of operand two and hysteresis band
  always @*
  begin
    if (ctrl[`ATC_CTRL_GAIN2_EN])
      eff2 = operand_second * $signed({18'h00000, gain_second});
    else
      eff2 = operand_second;
    band_hi = eff2 + $signed({18'h00000, switch_hysteresis});
    band_lo = eff2 - $signed({18'h00000, switch_hysteresis});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Signed compare flags
  assign cmp_below     = (eff1 < eff2);
  assign cmp_equal     = (eff1 == eff2);
  assign cmp_above     = (eff1 > eff2);
  assign cmp_not_above = (eff1 <= eff2);
  assign cmp_not_below = (eff1 >= eff2);
  assign over_band     = (eff1 > band_hi);
  assign under_band    = (eff1 < band_lo);

  ////////////////////////////////////////////////////////////////////////////////
  // Contact decision per mode
  always @*
  begin
    next_contact = contact_out;
    case (mode)
      `ATC_MODE_LESS:
      begin
        if (cmp_below)
          next_contact = 1'b1;
        else if (over_band)
          next_contact = 1'b0;
      end
      `ATC_MODE_LESS_EQUAL:
      begin
        if (cmp_not_above)
          next_contact = 1'b1;
        else if (over_band)
          next_contact = 1'b0;
      end
      `ATC_MODE_EQUAL:
      begin
        if (cmp_equal)
          next_contact = 1'b1;
        else if (over_band || under_band)
          next_contact = 1'b0;
      end
      `ATC_MODE_GREATER_EQUAL:
      begin
        if (cmp_not_below)
          next_contact = 1'b1;
        else if (under_band)
          next_contact = 1'b0;
      end
      `ATC_MODE_GREATER:
      begin
        if (cmp_above)
          next_contact = 1'b1;
        else if (under_band)
          next_contact = 1'b0;
      end
      default: next_contact = contact_out;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan sequencing: sample, then evaluate next cycle
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      operand_first  <= 32'h0000_0000;
      operand_second <= 32'h0000_0000;
      display_value  <= 32'h0000_0000;
      eval_pending   <= 1'b0;
      contact_out    <= 1'b0;
      eval_done_out  <= 1'b0;
    end
    else
    begin
      eval_done_out <= 1'b0;
      if (scan_start_in && enable_in)
      begin
        operand_first  <= raw1;
        operand_second <= raw2;
        if (src1_counter && raw1 > `ATC_DISP_LIMIT)
          display_value <= raw1 - `ATC_DISP_WRAP;
        else
          display_value <= raw1;
        eval_pending   <= 1'b1;
      end
      else
        eval_pending <= 1'b0;
      if (eval_pending)
      begin
        contact_out   <= next_contact;
        eval_done_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone register file
  always @*
  begin
    case (wb_adr_in)
      `ATC_REG_CTRL:      next_rd = ctrl;
      `ATC_REG_GAIN1:     next_rd = {18'h00000, gain_first};
      `ATC_REG_GAIN2:     next_rd = {18'h00000, gain_second};
      `ATC_REG_OFFSET1:   next_rd = {18'h00000, offset_first};
      `ATC_REG_HYST:      next_rd = {18'h00000, switch_hysteresis};
      `ATC_REG_SETPOINT1: next_rd = {18'h00000, setpoint_first};
      `ATC_REG_SETPOINT2: next_rd = {18'h00000, setpoint_second};
      `ATC_REG_STATUS:    next_rd = {31'h00000000, contact_out};
      `ATC_REG_VALUE1:    next_rd = eff1;
      `ATC_REG_VALUE2:    next_rd = eff2;
      `ATC_REG_DISPLAY:   next_rd = display_value;
      default:            next_rd = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter clipping
  function [13:0] atc_clip;
    input [31:0] v;
    begin
      if (v[31:14] != 18'h00000 || v[13:0] > `ATC_PARAM_MAX)
        atc_clip = `ATC_PARAM_MAX;
      else
        atc_clip = v[13:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and bus answer
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl              <= `ATC_CTRL_RESET;
      gain_first        <= 14'h0000;
      gain_second       <= 14'h0000;
      offset_first      <= 14'h0000;
      switch_hysteresis <= 14'h0000;
      setpoint_first    <= 14'h0000;
      setpoint_second   <= 14'h0000;
      wb_ack_out        <= 1'b0;
      wb_dat_out        <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= wb_req;
      if (wb_req)
        wb_dat_out <= next_rd;
      if (wb_write)
      begin
        case (wb_adr_in)
          `ATC_REG_CTRL:      ctrl <= wb_dat_in & 32'h0000_3777;
          `ATC_REG_GAIN1:     gain_first <= atc_clip(wb_dat_in);
          `ATC_REG_GAIN2:     gain_second <= atc_clip(wb_dat_in);
          `ATC_REG_OFFSET1:   offset_first <= atc_clip(wb_dat_in);
          `ATC_REG_HYST:      switch_hysteresis <= atc_clip(wb_dat_in);
          `ATC_REG_SETPOINT1: setpoint_first <= atc_clip(wb_dat_in);
          `ATC_REG_SETPOINT2: setpoint_second <= atc_clip(wb_dat_in);
          default:            ctrl <= ctrl;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/atc_comparator_unit_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"
module atc_comparator_unit_props
(
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  // Bus
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [5:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // Scan and contact
  input wire logic        scan_start_in,
  input wire logic        enable_in,
  input wire logic        contact_out,
  input wire logic        eval_done_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  chk_eval_on_scan: assert property (scan_start_in && enable_in |-> ##2 eval_done_out)
    else $error("no evaluation after scan");
  chk_no_eval_idle: assert property (!(scan_start_in && enable_in) |-> ##2 !eval_done_out)
    else $error("evaluation without scan");
  chk_contact_held: assert property (!(scan_start_in && enable_in) |-> ##2 $stable(contact_out))
    else $error("contact moved between scans");
  chk_done_single: assert property (eval_done_out |=> !eval_done_out)
    else $error("done longer than one cycle");
  chk_status_bit: assert property (wb_ack_out && !wb_we_in && wb_adr_in == `ATC_REG_STATUS
    && !$past(scan_start_in) && !$past(scan_start_in, 2) |-> wb_dat_out[0] == contact_out)
    else $error("status differs from contact");
  chk_ack_delay: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  chk_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 6'h28
    |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind atc_comparator_unit atc_comparator_unit_props chk_u
(
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .scan_start_in(scan_start_in),
  .enable_in(enable_in), .contact_out(contact_out), .eval_done_out(eval_done_out)
);
`default_nettype wire

// *** sim/tb_atc_comparator_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"
module tb_atc_comparator_unit;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        sc = 1'b0, en = 1'b0, ack, done, contact, ec = 1'b0;
  logic [5:0]  adr = 6'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [9:0]  an_a = 10'h0, an_b = 10'h0;
  logic [15:0] cnt = 16'h0, tmr = 16'h0;
  logic [31:0] rq[$];
  logic        cq[$];
  int          mismatches = 0, comparisons = 0, cycles = 0, m = 0, sp = 100, h = 25, i, r;
  int          pts[7] = '{126, 100, 101, 99, 125, 74, 75};
  atc_comparator_unit dut_u
  (
    .ref_clk_in(clk), .reset_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .analog_in_a_in(an_a), .analog_in_b_in(an_b),
    .counter_value_in(cnt), .timer_value_in(tmr), .scan_start_in(sc),
    .enable_in(en), .contact_out(contact), .eval_done_out(done)
  );
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Bus, scan and compare tasks
  task give_verdict;
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cmp_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cmp_bit(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    if (!w) rq.push_back(d);
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  function logic nxt(int x);
    case (m)
      0: nxt = x < sp ? 1'b1 : x > sp + h ? 1'b0 : ec;
      1: nxt = x <= sp ? 1'b1 : x > sp + h ? 1'b0 : ec;
      2: nxt = x == sp ? 1'b1 : (x > sp + h || x < sp - h) ? 1'b0 : ec;
      3: nxt = x >= sp ? 1'b1 : x < sp - h ? 1'b0 : ec;
      default: nxt = x > sp ? 1'b1 : x < sp - h ? 1'b0 : ec;
    endcase
  endfunction
  task scan(input logic [9:0] x, input int e, input logic g);
    @(posedge clk);
    an_a <= x; an_b <= 10'($urandom); sc <= 1'b1; en <= g;
    if (g) ec = nxt(e);
    if (g) cq.push_back(ec);
    @(posedge clk);
    sc <= 1'b0;
    @(posedge clk);
  endtask
  function logic [31:0] cw(int md, logic [2:0] s1, logic [2:0] s2, logic g1, logic g2);
    cw = {18'h0, g2, g1, 1'b0, s2, 1'b0, s1, 1'b0, 3'(md)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Result monitor and timeout
  always @(posedge clk)
  begin
    if (ack && !we) cmp_word(rdat, rq.pop_front());
    if (done) cmp_bit(contact, cq.pop_front());
    if (++cycles == 8000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'h19AE4D1A));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `ATC_REG_CTRL, `ATC_CTRL_RESET);
    bus(1, `ATC_REG_GAIN1, 32'h0000_FFFF);
    bus(0, `ATC_REG_GAIN1, {18'h0, `ATC_PARAM_MAX});
    bus(0, 6'h3C, 32'h0);
    bus(1, `ATC_REG_STATUS, 32'h1);
    bus(1, `ATC_REG_SETPOINT2, 32'd100);
    bus(1, `ATC_REG_HYST, 32'd25);
    for (m = 0; m < 5; m++)
    begin
      bus(1, `ATC_REG_CTRL, cw(m, `ATC_SRC_ANALOG_A, `ATC_SRC_SETPOINT, 0, 0));
      for (i = 0; i < 14; i++)
      begin
        r = i < 7 ? pts[i] : 60 + $urandom % 81;
        scan(10'(r), r, 1);
      end
    end
    m = 3;
    scan(10'h0, 0, 0);
    bus(0, `ATC_REG_STATUS, {31'h0, ec});
    bus(1, `ATC_REG_GAIN1, 32'd10);
    bus(1, `ATC_REG_OFFSET1, 32'd5);
    bus(1, `ATC_REG_SETPOINT2, 32'd300);
    bus(1, `ATC_REG_CTRL, cw(3, `ATC_SRC_ANALOG_A, `ATC_SRC_SETPOINT, 1, 0));
    sp = 300;
    scan(10'd30, 305, 1);
    bus(0, `ATC_REG_VALUE1, 32'd305);
    scan(10'd27, 275, 1);
    scan(10'd26, 265, 1);
    cnt <= 16'd10233;
    bus(1, `ATC_REG_GAIN2, 32'd9999);
    bus(1, `ATC_REG_SETPOINT2, 32'd9999);
    bus(1, `ATC_REG_CTRL, cw(3, `ATC_SRC_COUNTER, `ATC_SRC_SETPOINT, 0, 1));
    sp = `ATC_PARAM_MAX * `ATC_PARAM_MAX;
    scan(10'd0, 10238, 1);
    bus(0, `ATC_REG_DISPLAY, 32'd233);
    bus(0, `ATC_REG_VALUE1, 32'd10238);
    bus(0, `ATC_REG_VALUE2, sp);
    tmr <= 16'd10040;
    bus(1, `ATC_REG_CTRL, cw(3, `ATC_SRC_TIMER, `ATC_SRC_SETPOINT, 0, 0));
    sp = 9999;
    scan(10'd0, 10045, 1);
    bus(0, `ATC_REG_DISPLAY, 32'd10040);
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule
`default_nettype wire
